/* File: src/ppha_defs.vh */
// constants of the peripheral port handshake adapter
// assumes a 32-bit APB slave decode on word-aligned byte addresses
//
// Notes on behaviour
// - two 8-bit ports, per-line direction
// - strobe edge sets flag 7; bit 1 picks edge
// - control bit 0 gates flag 7 onto irq
// - line input mode: bit 4 edge, bit 3 enable
// - line edge sets flag 6 regardless of bit 3
// - A read handshake: strobe raises, data read lowers
// - A pulse: line low one cycle after read
// - B write handshake: data write lowers, strobe raises
// - B pulse: line low one cycle after write
`ifndef PPHA_DEFS_VH
`define PPHA_DEFS_VH

// ************************************************************
// register word offsets, decoded from paddr bits 7..2
// ************************************************************
`define PPHA_OFF_A_DATA   6'h00
`define PPHA_OFF_A_DIR    6'h01
`define PPHA_OFF_A_CTL    6'h02
`define PPHA_OFF_B_DATA   6'h03
`define PPHA_OFF_B_DIR    6'h04
`define PPHA_OFF_B_CTL    6'h05
`define PPHA_OFF_IRQ_STS  6'h06
`define PPHA_OFF_IRQ_MSK  6'h07

// ************************************************************
// control register fields
// ************************************************************
`define PPHA_CTL_STR_EN   0
`define PPHA_CTL_STR_POS  1
`define PPHA_CTL_LINE_EN  3
`define PPHA_CTL_LINE_POS 4
`define PPHA_CTL_LINE_OUT 5
`define PPHA_CTL_FLAG_LN  6
`define PPHA_CTL_FLAG_ST  7

// line output modes, control bits 5..3
`define PPHA_MODE_HSHAKE  3'h4
`define PPHA_MODE_PULSE   3'h5
`define PPHA_MODE_MAN_LO  3'h6
`define PPHA_MODE_MAN_HI  3'h7

// ************************************************************
// interrupt status bits and reset values
// ************************************************************
`define PPHA_IRQ_A_STR    0
`define PPHA_IRQ_A_LINE   1
`define PPHA_IRQ_B_STR    2
`define PPHA_IRQ_B_LINE   3
`define PPHA_IRQ_W        4
`define PPHA_RST_BYTE     8'h00
`define PPHA_RST_CTL      6'h00
`define PPHA_RST_IRQ      4'h0

`endif

/* File: src/ppha_edge.v */
// synchroniser and selectable edge detector for one pin
// assumes pin_i is asynchronous to clk_i
`timescale 1ns/10ps
module ppha_edge (
  input  wire clk_i,
  input  wire rst_i,
  input  wire pin_i,
  input  wire rise_sel_i,
  output wire level_o,
  output wire edge_o
);
  reg sync1_q;
  reg sync2_q;
  reg prev_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
    end else begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  assign level_o = sync2_q;
  assign edge_o  = rise_sel_i ? (sync2_q & ~prev_q) : (~sync2_q & prev_q);
endmodule // ppha_edge

/* File: src/ppha_irq.v */
// sticky interrupt status, write-one-to-clear, with mask
// assumes event pulses and write strobes on clk_i
`timescale 1ns/10ps
`include "ppha_defs.vh"
module ppha_irq (
  input  wire                 clk_i,
  input  wire                 rst_i,
  input  wire [`PPHA_IRQ_W-1:0] evt_i,
  input  wire                 sts_wr_i,
  input  wire                 msk_wr_i,
  input  wire [`PPHA_IRQ_W-1:0] wdata_i,
  output wire [`PPHA_IRQ_W-1:0] sts_o,
  output wire [`PPHA_IRQ_W-1:0] msk_o,
  output wire                 irq_o
);
  reg  [`PPHA_IRQ_W-1:0] sts_q;
  reg  [`PPHA_IRQ_W-1:0] msk_q;
  wire [`PPHA_IRQ_W-1:0] clr;

  assign clr = sts_wr_i ? wdata_i : {`PPHA_IRQ_W{1'b0}};

  always @(posedge clk_i) begin
    if (rst_i) begin
      sts_q <= `PPHA_RST_IRQ;
      msk_q <= `PPHA_RST_IRQ;
    end else begin
      // a new event wins over a clear in the same cycle
      sts_q <= (sts_q & ~clr) | evt_i;
      if (msk_wr_i) begin
        msk_q <= wdata_i;
      end
    end
  end

  assign sts_o = sts_q;
  assign msk_o = msk_q;
  assign irq_o = |(sts_q & msk_q);
endmodule // ppha_irq

/* File: src/ppha_top.v */
// dual 8-bit peripheral port with control lines, handshakes and irq
// assumes an APB master on clk_i; pins are asynchronous and synced here
`timescale 1ns/10ps
`include "ppha_defs.vh"
module ppha_top (
  input  wire        clk_i,
  input  wire        rst_i,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  // port a
  input  wire [7:0]  port_a_pin_i,
  output wire [7:0]  port_a_pin_o,
  output wire [7:0]  port_a_pin_oe_o,
  input  wire        port_a_strobe_in_i,
  input  wire        port_a_ctrl_line_i,
  output wire        port_a_ctrl_line_o,
  output wire        port_a_ctrl_line_oe_o,
  output wire        port_a_irq_n_o,
  // port b
  input  wire [7:0]  port_b_pin_i,
  output wire [7:0]  port_b_pin_o,
  output wire [7:0]  port_b_pin_oe_o,
  input  wire        port_b_strobe_in_i,
  input  wire        port_b_ctrl_line_i,
  output wire        port_b_ctrl_line_o,
  output wire        port_b_ctrl_line_oe_o,
  output wire        port_b_irq_n_o,
  // combined interrupt
  output wire        irq_o
);

  // ************************************************************
  // state
  // ************************************************************
  reg  [7:0]  a_data_q;
  reg  [7:0]  a_dir_q;
  reg  [5:0]  a_ctl_q;
  reg         a_fst_q;
  reg         a_fln_q;
  reg         a_line_q;
  reg         a_line_d;
  reg  [7:0]  b_data_q;
  reg  [7:0]  b_dir_q;
  reg  [5:0]  b_ctl_q;
  reg         b_fst_q;
  reg         b_fln_q;
  reg         b_line_q;
  reg         b_line_d;
  reg  [7:0]  a_sync1_q;
  reg  [7:0]  a_sync2_q;
  reg  [7:0]  b_sync1_q;
  reg  [7:0]  b_sync2_q;
  reg  [31:0] rdata_q;
  reg  [31:0] rdata_d;
  reg         err_q;
  reg         err_d;

  wire [5:0]  idx;
  wire        setup;
  wire        access;
  wire        wr;
  wire        rd;
  wire        a_data_rd;
  wire        b_data_rd;
  wire        b_data_wr;
  wire        a_str_edge;
  wire        a_ln_edge;
  wire        b_str_edge;
  wire        b_ln_edge;
  wire        a_ln_evt;
  wire        b_ln_evt;
  wire [7:0]  a_rd_val;
  wire [7:0]  b_rd_val;
  wire [3:0]  irq_sts;
  wire [3:0]  irq_msk;
  wire [3:0]  irq_evt;
  wire        a_irq;
  wire        b_irq;

  // ************************************************************
  // apb decode
  // ************************************************************
  assign idx    = paddr_i[7:2];
  assign setup  = psel_i & ~penable_i;
  assign access = psel_i & penable_i;
  assign wr     = access & pwrite_i;
  assign rd     = access & ~pwrite_i;

  assign a_data_rd = rd & (idx == `PPHA_OFF_A_DATA);
  assign b_data_rd = rd & (idx == `PPHA_OFF_B_DATA);
  assign b_data_wr = wr & (idx == `PPHA_OFF_B_DATA);

  // ************************************************************
  // pin synchronisers and edge detectors
  // ************************************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      a_sync1_q <= `PPHA_RST_BYTE;
      a_sync2_q <= `PPHA_RST_BYTE;
      b_sync1_q <= `PPHA_RST_BYTE;
      b_sync2_q <= `PPHA_RST_BYTE;
    end else begin
      a_sync1_q <= port_a_pin_i;
      a_sync2_q <= a_sync1_q;
      b_sync1_q <= port_b_pin_i;
      b_sync2_q <= b_sync1_q;
    end
  end

  ppha_edge u_a_str (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .pin_i      (port_a_strobe_in_i),
    .rise_sel_i (a_ctl_q[`PPHA_CTL_STR_POS]),
    .level_o    (),
    .edge_o     (a_str_edge)
  );

  ppha_edge u_a_ln (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .pin_i      (port_a_ctrl_line_i),
    .rise_sel_i (a_ctl_q[`PPHA_CTL_LINE_POS]),
    .level_o    (),
    .edge_o     (a_ln_edge)
  );

  ppha_edge u_b_str (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .pin_i      (port_b_strobe_in_i),
    .rise_sel_i (b_ctl_q[`PPHA_CTL_STR_POS]),
    .level_o    (),
    .edge_o     (b_str_edge)
  );

  ppha_edge u_b_ln (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .pin_i      (port_b_ctrl_line_i),
    .rise_sel_i (b_ctl_q[`PPHA_CTL_LINE_POS]),
    .level_o    (),
    .edge_o     (b_ln_edge)
  );

  // line edges count only while the line is an input
  assign a_ln_evt = a_ln_edge & ~a_ctl_q[`PPHA_CTL_LINE_OUT];
  assign b_ln_evt = b_ln_edge & ~b_ctl_q[`PPHA_CTL_LINE_OUT];

  // ************************************************************
  // port registers and flags
  // ************************************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      a_data_q <= `PPHA_RST_BYTE;
      a_dir_q  <= `PPHA_RST_BYTE;
      a_ctl_q  <= `PPHA_RST_CTL;
      b_data_q <= `PPHA_RST_BYTE;
      b_dir_q  <= `PPHA_RST_BYTE;
      b_ctl_q  <= `PPHA_RST_CTL;
    end else begin
      if (wr && idx == `PPHA_OFF_A_DATA) begin
        a_data_q <= pwdata_i[7:0];
      end
      if (wr && idx == `PPHA_OFF_A_DIR) begin
        a_dir_q <= pwdata_i[7:0];
      end
      if (wr && idx == `PPHA_OFF_A_CTL) begin
        a_ctl_q <= pwdata_i[5:0];
      end
      if (b_data_wr) begin
        b_data_q <= pwdata_i[7:0];
      end
      if (wr && idx == `PPHA_OFF_B_DIR) begin
        b_dir_q <= pwdata_i[7:0];
      end
      if (wr && idx == `PPHA_OFF_B_CTL) begin
        b_ctl_q <= pwdata_i[5:0];
      end
    end
  end

  // flags: an edge wins over the clearing data read
  always @(posedge clk_i) begin
    if (rst_i) begin
      a_fst_q <= 1'b0;
      a_fln_q <= 1'b0;
      b_fst_q <= 1'b0;
      b_fln_q <= 1'b0;
    end else begin
      if (a_str_edge) begin
        a_fst_q <= 1'b1;
      end else if (a_data_rd) begin
        a_fst_q <= 1'b0;
      end
      if (a_ln_evt) begin
        a_fln_q <= 1'b1;
      end else if (a_data_rd) begin
        a_fln_q <= 1'b0;
      end
      if (b_str_edge) begin
        b_fst_q <= 1'b1;
      end else if (b_data_rd) begin
        b_fst_q <= 1'b0;
      end
      if (b_ln_evt) begin
        b_fln_q <= 1'b1;
      end else if (b_data_rd) begin
        b_fln_q <= 1'b0;
      end
    end
  end

  // ************************************************************
  // control line outputs
  // ************************************************************
  always @* begin
    case (a_ctl_q[5:3])
      `PPHA_MODE_HSHAKE: begin
        if (a_str_edge) begin
          a_line_d = 1'b1;
        end else if (a_data_rd) begin
          a_line_d = 1'b0;
        end else begin
          a_line_d = a_line_q;
        end
      end
      `PPHA_MODE_PULSE:  a_line_d = ~a_data_rd;
      `PPHA_MODE_MAN_LO: a_line_d = 1'b0;
      `PPHA_MODE_MAN_HI: a_line_d = 1'b1;
      default:           a_line_d = 1'b1;
    endcase
  end

  always @* begin
    case (b_ctl_q[5:3])
      `PPHA_MODE_HSHAKE: begin
        if (b_data_wr) begin
          b_line_d = 1'b0;
        end else if (b_str_edge) begin
          b_line_d = 1'b1;
        end else begin
          b_line_d = b_line_q;
        end
      end
      `PPHA_MODE_PULSE:  b_line_d = ~b_data_wr;
      `PPHA_MODE_MAN_LO: b_line_d = 1'b0;
      `PPHA_MODE_MAN_HI: b_line_d = 1'b1;
      default:           b_line_d = 1'b1;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      a_line_q <= 1'b1;
      b_line_q <= 1'b1;
    end else begin
      a_line_q <= a_line_d;
      b_line_q <= b_line_d;
    end
  end

  assign port_a_ctrl_line_o    = a_line_q;
  assign port_b_ctrl_line_o    = b_line_q;
  assign port_a_ctrl_line_oe_o = a_ctl_q[`PPHA_CTL_LINE_OUT];
  assign port_b_ctrl_line_oe_o = b_ctl_q[`PPHA_CTL_LINE_OUT];

  // ************************************************************
  // port pins
  // ************************************************************
  assign port_a_pin_o    = a_data_q;
  assign port_a_pin_oe_o = a_dir_q;
  assign port_b_pin_o    = b_data_q;
  assign port_b_pin_oe_o = b_dir_q;

  // output lines read back the latch, input lines the pin
  assign a_rd_val = (a_dir_q & a_data_q) | (~a_dir_q & a_sync2_q);
  assign b_rd_val = (b_dir_q & b_data_q) | (~b_dir_q & b_sync2_q);

  // ************************************************************
  // interrupts
  // ************************************************************
  assign a_irq = (a_fst_q & a_ctl_q[`PPHA_CTL_STR_EN]) |
                 (a_fln_q & a_ctl_q[`PPHA_CTL_LINE_EN] &
                  ~a_ctl_q[`PPHA_CTL_LINE_OUT]);
  assign b_irq = (b_fst_q & b_ctl_q[`PPHA_CTL_STR_EN]) |
                 (b_fln_q & b_ctl_q[`PPHA_CTL_LINE_EN] &
                  ~b_ctl_q[`PPHA_CTL_LINE_OUT]);
  assign port_a_irq_n_o = ~a_irq;
  assign port_b_irq_n_o = ~b_irq;

  assign irq_evt = {b_ln_evt, b_str_edge, a_ln_evt, a_str_edge};

  ppha_irq u_irq (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .evt_i    (irq_evt),
    .sts_wr_i (wr && idx == `PPHA_OFF_IRQ_STS),
    .msk_wr_i (wr && idx == `PPHA_OFF_IRQ_MSK),
    .wdata_i  (pwdata_i[3:0]),
    .sts_o    (irq_sts),
    .msk_o    (irq_msk),
    .irq_o    (irq_o)
  );

  // ************************************************************
  // read data, captured in the setup cycle
  // ************************************************************
  always @* begin
    rdata_d = 32'h00000000;
    err_d   = 1'b0;
    case (idx)
      `PPHA_OFF_A_DATA:  rdata_d[7:0] = a_rd_val;
      `PPHA_OFF_A_DIR:   rdata_d[7:0] = a_dir_q;
      `PPHA_OFF_A_CTL:   rdata_d[7:0] = {a_fst_q, a_fln_q, a_ctl_q};
      `PPHA_OFF_B_DATA:  rdata_d[7:0] = b_rd_val;
      `PPHA_OFF_B_DIR:   rdata_d[7:0] = b_dir_q;
      `PPHA_OFF_B_CTL:   rdata_d[7:0] = {b_fst_q, b_fln_q, b_ctl_q};
      `PPHA_OFF_IRQ_STS: rdata_d[3:0] = irq_sts;
      `PPHA_OFF_IRQ_MSK: rdata_d[3:0] = irq_msk;
      default:           err_d = 1'b1;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h00000000;
      err_q   <= 1'b0;
    end else if (setup) begin
      rdata_q <= pwrite_i ? 32'h00000000 : rdata_d;
      err_q   <= err_d;
    end
  end

  assign prdata_o  = rdata_q;
  assign pready_o  = access;
  assign pslverr_o = access & err_q;

endmodule // ppha_top

/* File: tb/ppha_periph.sv */
// behavioural peripheral device beside the two ports
// assumes the bench calls its tasks from one process
`timescale 1ns/10ps
module ppha_periph (
  input  wire       clk_i,
  output reg  [7:0] data_o,
  output reg        strb_a_o,
  output reg        strb_b_o,
  output reg        line_a_o,
  output reg        line_b_o
);
  initial begin
    data_o = 8'h3c;
    strb_a_o = 1'b0;
    strb_b_o = 1'b0;
    line_a_o = 1'b0;
    line_b_o = 1'b1;
  end
  // new data first, then the strobe edge
  task automatic send_a(input logic [7:0] d, input logic v);
    @(posedge clk_i);
    data_o <= d;
    @(posedge clk_i);
    strb_a_o <= v;
  endtask
  // data taken from port b
  task automatic ack_b(input logic v);
    @(posedge clk_i);
    strb_b_o <= v;
  endtask
  task automatic line_a(input logic v);
    @(posedge clk_i);
    line_a_o <= v;
  endtask
endmodule // ppha_periph

/* File: tb/ppha_monitor.sv */
// port checker for the peripheral port adapter
// assumes binding into ppha_top, one clock, synchronous reset
`timescale 1ns/10ps
`include "ppha_defs.vh"
module ppha_monitor (
  input wire        clk_i,
  input wire        rst_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire        pwrite_i,
  input wire [7:0]  paddr_i,
  input wire [31:0] pwdata_i,
  input wire [31:0] prdata_o,
  input wire        pready_o,
  input wire        pslverr_o,
  input wire        port_a_strobe_in_i,
  input wire        port_a_ctrl_line_i,
  input wire        port_a_ctrl_line_o,
  input wire        port_a_ctrl_line_oe_o,
  input wire        port_a_irq_n_o,
  input wire        port_b_ctrl_line_o,
  input wire        irq_o
);
  // ****
  // decode and shadow registers
  // ****
  wire       acc = psel_i & penable_i;
  wire [5:0] idx = paddr_i[7:2];
  wire       rd_a = acc & ~pwrite_i & (idx == `PPHA_OFF_A_DATA);
  wire       wr_b = acc & pwrite_i & (idx == `PPHA_OFF_B_DATA);
  wire       wc_a = acc & pwrite_i & (idx == `PPHA_OFF_A_CTL);
  wire       wc_b = acc & pwrite_i & (idx == `PPHA_OFF_B_CTL);
  reg  [5:0] ca_q;
  reg  [5:0] cb_q;
  reg  [3:0] mk_q;
  reg  [3:0] sa_q;
  reg  [3:0] la_q;
  wire       quiet = (sa_q == {4{port_a_strobe_in_i}}) & (la_q == {4{port_a_ctrl_line_i}});
  always @(posedge clk_i) begin
    if (rst_i) begin
      ca_q <= 6'h00;
      cb_q <= 6'h00;
      mk_q <= 4'h0;
    end else begin
      if (wc_a) ca_q <= pwdata_i[5:0];
      if (wc_b) cb_q <= pwdata_i[5:0];
      if (acc & pwrite_i & (idx == `PPHA_OFF_IRQ_MSK)) mk_q <= pwdata_i[3:0];
    end
    sa_q <= {sa_q[2:0], port_a_strobe_in_i};
    la_q <= {la_q[2:0], port_a_ctrl_line_i};
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  rdy_access_a: assert property (psel_i && !penable_i ##1 acc |-> pready_o)
    else $error("pready missing");
  bad_addr_a: assert property (acc |-> pslverr_o == (idx > 6'h07))
    else $error("slave error wrong");
  irq_gate_a: assert property (!port_a_irq_n_o |-> ca_q[0] | (ca_q[3] & ~ca_q[5]))
    else $error("irq low while disabled");
  read_clear_a: assert property (rd_a && quiet |=> port_a_irq_n_o)
    else $error("irq kept after data read");
  hs_read_a: assert property (
    rd_a && quiet && ca_q[5:3] == `PPHA_MODE_HSHAKE |=> !port_a_ctrl_line_o)
    else $error("read handshake line high");
  pulse_read_a: assert property (
    rd_a && ca_q[5:3] == `PPHA_MODE_PULSE |=> !port_a_ctrl_line_o ##1 port_a_ctrl_line_o)
    else $error("read pulse wrong");
  hs_write_a: assert property (
    wr_b && cb_q[5:3] == `PPHA_MODE_HSHAKE |=> !port_b_ctrl_line_o)
    else $error("write handshake line high");
  pulse_write_a: assert property (
    wr_b && cb_q[5:3] == `PPHA_MODE_PULSE |=> !port_b_ctrl_line_o ##1 port_b_ctrl_line_o)
    else $error("write pulse wrong");
  // control lands at the write edge, the line one edge later
  man_low_a: assert property (
    wc_b && pwdata_i[5:3] == `PPHA_MODE_MAN_LO |=> ##1 !port_b_ctrl_line_o [*3])
    else $error("manual low not held");
  man_high_a: assert property (
    wc_a && pwdata_i[5:3] == `PPHA_MODE_MAN_HI |=> ##1 port_a_ctrl_line_o [*3])
    else $error("manual high not held");
  line_dir_a: assert property (wc_a |=> port_a_ctrl_line_oe_o == $past(pwdata_i[5]))
    else $error("line direction wrong");
  mask_off_a: assert property (mk_q == 4'h0 |-> !irq_o)
    else $error("irq with empty mask");
endmodule // ppha_monitor
bind ppha_top ppha_monitor mon_u (.*);

/* File: tb/testbench.sv */
// self-checking bench for the peripheral port adapter
// assumes ppha_top, ppha_periph and ppha_monitor are compiled
`timescale 1ns/10ps
`include "ppha_defs.vh"
module testbench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd_q;
  logic        pready, perr, err_q;
  logic [7:0]  a_o, a_oe, b_o, b_oe, pd;
  logic        la_o, la_oe, lb_o, lb_oe, sa, sb, pla, plb, irq_a_n, irq_b_n, irq;
  int          n_errors = 0;
  int          num_checks = 0;
  always #4 clk_i = ~clk_i;
  ppha_periph per_u (.clk_i(clk_i), .data_o(pd), .strb_a_o(sa), .strb_b_o(sb),
    .line_a_o(pla), .line_b_o(plb));
  ppha_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(perr), .port_a_pin_i((a_oe & a_o) | (~a_oe & pd)),
    .port_a_pin_o(a_o), .port_a_pin_oe_o(a_oe), .port_a_strobe_in_i(sa),
    .port_a_ctrl_line_i(la_oe ? la_o : pla), .port_a_ctrl_line_o(la_o),
    .port_a_ctrl_line_oe_o(la_oe), .port_a_irq_n_o(irq_a_n),
    .port_b_pin_i((b_oe & b_o) | (~b_oe & pd)), .port_b_pin_o(b_o),
    .port_b_pin_oe_o(b_oe), .port_b_strobe_in_i(sb),
    .port_b_ctrl_line_i(lb_oe ? lb_o : plb), .port_b_ctrl_line_o(lb_o),
    .port_b_ctrl_line_oe_o(lb_oe), .port_b_irq_n_o(irq_b_n), .irq_o(irq));
  // ****
  // bus and compare tasks
  // ****
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [5:0] i, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rd_q = prdata;
    err_q = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] i, input logic [31:0] e);
    apb(1'b0, i, 32'h0);
    chk(rd_q, e);
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset;
    chk({la_o, la_oe, lb_o, lb_oe, irq_a_n, irq_b_n, irq}, 32'h56);
    rd(`PPHA_OFF_A_CTL, 32'h0);
    rd(`PPHA_OFF_IRQ_STS, 32'h0);
  endtask
  task automatic t_dir;
    apb(1'b1, `PPHA_OFF_A_DIR, 32'h0f);
    apb(1'b1, `PPHA_OFF_A_DATA, 32'ha5);
    apb(1'b1, `PPHA_OFF_B_DIR, 32'hf0);
    apb(1'b1, `PPHA_OFF_B_DATA, 32'h96);
    w(4);
    chk({a_oe, a_o, b_oe, b_o}, 32'h0fa5f096);
    rd(`PPHA_OFF_A_DATA, 32'h35);
    rd(`PPHA_OFF_B_DATA, 32'h9c);
  endtask
  task automatic t_strobe;
    apb(1'b1, `PPHA_OFF_A_CTL, 32'h03);
    per_u.send_a(8'h5a, 1'b1);
    w(6);
    chk(irq_a_n, 1'b0);
    rd(`PPHA_OFF_A_CTL, 32'h83);
    rd(`PPHA_OFF_A_DATA, 32'h55);
    rd(`PPHA_OFF_A_CTL, 32'h03);
    chk(irq_a_n, 1'b1);
    per_u.send_a(8'h5a, 1'b0);
    w(6);
    rd(`PPHA_OFF_A_CTL, 32'h03);
    apb(1'b1, `PPHA_OFF_A_CTL, 32'h00);
    per_u.send_a(8'h5a, 1'b1);
    per_u.send_a(8'h5a, 1'b0);
    w(6);
    chk(irq_a_n, 1'b1);
    rd(`PPHA_OFF_A_CTL, 32'h80);
    rd(`PPHA_OFF_A_DATA, 32'h55);
  endtask
  task automatic t_line;
    apb(1'b1, `PPHA_OFF_A_CTL, 32'h18);
    per_u.line_a(1'b1);
    w(6);
    chk(irq_a_n, 1'b0);
    rd(`PPHA_OFF_A_CTL, 32'h58);
    rd(`PPHA_OFF_A_DATA, 32'h55);
    apb(1'b1, `PPHA_OFF_A_CTL, 32'h10);
    per_u.line_a(1'b0);
    w(6);
    rd(`PPHA_OFF_A_CTL, 32'h10);
    per_u.line_a(1'b1);
    w(6);
    chk(irq_a_n, 1'b1);
    rd(`PPHA_OFF_A_CTL, 32'h50);
  endtask
  task automatic t_hs_a;
    apb(1'b1, `PPHA_OFF_A_CTL, 32'h22);
    rd(`PPHA_OFF_A_DATA, 32'h55);
    w(1);
    chk({la_oe, la_o}, 32'h2);
    per_u.send_a(8'h69, 1'b1);
    w(6);
    chk(la_o, 1'b1);
    rd(`PPHA_OFF_A_DATA, 32'h65);
    w(1);
    chk(la_o, 1'b0);
    apb(1'b1, `PPHA_OFF_A_CTL, 32'h3a);
    apb(1'b1, `PPHA_OFF_A_CTL, 32'h2a);
    rd(`PPHA_OFF_A_DATA, 32'h65);
    w(1);
    chk(la_o, 1'b0);
    w(1);
    chk(la_o, 1'b1);
  endtask
  task automatic t_hs_b;
    apb(1'b1, `PPHA_OFF_B_CTL, 32'h22);
    apb(1'b1, `PPHA_OFF_B_DATA, 32'h11);
    w(1);
    chk({lb_oe, lb_o}, 32'h2);
    per_u.ack_b(1'b1);
    w(6);
    chk(lb_o, 1'b1);
    rd(`PPHA_OFF_B_CTL, 32'ha2);
    apb(1'b1, `PPHA_OFF_B_CTL, 32'h2a);
    apb(1'b1, `PPHA_OFF_B_DATA, 32'h22);
    w(1);
    chk(lb_o, 1'b0);
    w(1);
    chk(lb_o, 1'b1);
    apb(1'b1, `PPHA_OFF_B_CTL, 32'h30);
    w(2);
    chk(lb_o, 1'b0);
    apb(1'b1, `PPHA_OFF_B_CTL, 32'h38);
    w(2);
    chk(lb_o, 1'b1);
  endtask
  task automatic t_irq;
    apb(1'b1, `PPHA_OFF_IRQ_STS, 32'hf);
    rd(`PPHA_OFF_IRQ_STS, 32'h0);
    per_u.ack_b(1'b0);
    w(6);
    rd(`PPHA_OFF_IRQ_STS, 32'h4);
    apb(1'b1, `PPHA_OFF_B_CTL, 32'h39);
    w(1);
    chk(irq_b_n, 1'b0);
    rd(`PPHA_OFF_B_DATA, 32'h29);
    w(1);
    chk(irq_b_n, 1'b1);
    chk(irq, 1'b0);
    apb(1'b1, `PPHA_OFF_IRQ_MSK, 32'h4);
    w(1);
    chk(irq, 1'b1);
    rd(`PPHA_OFF_IRQ_MSK, 32'h4);
    apb(1'b1, `PPHA_OFF_IRQ_STS, 32'h4);
    w(1);
    chk(irq, 1'b0);
    rd(6'h08, 32'h0);
    chk(err_q, 1'b1);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    w(3);
    t_reset;
    t_dir;
    t_strobe;
    t_line;
    t_hs_a;
    t_hs_b;
    t_irq;
    print_verdict;
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    n_errors++;
    print_verdict;
  end
endmodule // testbench
